// File: bench/cacd_decoder_chk_chk.sv
// port checker for the authentication command decoder
`timescale 1ns/10ps
`default_nettype none
module cacd_decoder_chk (
   // apb and engine
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        alg_start,
   input wire logic [4:0]  alg_context
);
   logic [31:0] cmd_q;
   logic [7:0]  lc_q;
   logic [15:0] ga_q;
   wire         wr   = psel && penable && pwrite;
   wire         exec = wr && paddr == 12'h000 && pwdata[0];
   wire  [4:0]  ctx  = cmd_q[20:16];
   wire         ga   = ga_q[7] || ga_q[15];
   // shadows of what software last wrote
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_q <= '0;
         lc_q  <= '0;
         ga_q  <= '0;
      end else if (wr) begin
         if (paddr == 12'h008) cmd_q <= pwdata;
         if (paddr == 12'h00c) lc_q <= pwdata[7:0];
         if (paddr == 12'h010) ga_q <= pwdata[15:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_start_cause: assert property (alg_start |-> $past(exec && pwdata[2:1] == 2'b11))
      else $error("engine start without a permitted exec");
   a_ins_gate: assert property (exec && cmd_q[7:0] != 8'h88 |=> !alg_start)
      else $error("start with a foreign instruction");
   a_p2_gate: assert property (exec && (!cmd_q[23] || cmd_q[22:21] != 2'b00) |=> !alg_start)
      else $error("start with malformed reference byte");
   a_ctx_match: assert property (alg_start && !ga |-> alg_context == ctx)
      else $error("context code differs from command");
   a_rsvd_gate: assert property (exec && !ga && (ctx == 5'h00 || ctx > 5'h08) |=> !alg_start)
      else $error("reserved context executed");
   a_len_gate: assert property (exec && ((ctx == 5'h01 && lc_q != 8'h14) ||
      (ctx == 5'h02 && lc_q != 8'h0e)) |=> !alg_start)
      else $error("start despite wrong data length");
   a_ctx_hold: assert property (alg_start |=> $stable(alg_context))
      else $error("context moved during run");
   a_start_single: assert property (alg_start |=> !alg_start)
      else $error("start longer than one cycle");
   c_mgk: cover property (alg_start && alg_context == 5'h07);
   c_refused: cover property (exec ##1 !alg_start);
   c_two_runs: cover property (alg_start ##[1:40] alg_start);
endmodule
bind cacd_decoder cacd_decoder_chk cacd_decoder_chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .alg_start(alg_start), .alg_context(alg_context));
`default_nettype wire

// File: bench/cacd_engine.sv
// algorithm engine model on the far side of the decoder
`timescale 1ns/10ps
`default_nettype none
module cacd_engine (
   // decoder side
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        alg_start,
   input  wire logic [4:0]  alg_context,
   output var  logic        alg_done,
   output var  logic        alg_manipulated,
   output var  logic        alg_net_fail,
   output var  logic [79:0] alg_result,
   // bench controls
   input  wire logic        manip,
   input  wire logic        net_fail,
   input  wire logic [3:0]  delay
);
   logic [4:0]  cnt;
   logic [4:0]  ctx;
   logic [79:0] noise;
   logic [79:0] res;
   // byte n of the result is {low four context bits, n} so the byte order shows
   always_comb begin
      for (int n = 1; n <= 10; n++) res[87-8*n -: 8] = {ctx[3:0], 4'(n)};
   end
   // outside the done cycle the lines toggle, never hold
   assign alg_result      = alg_done ? res : noise;
   assign alg_manipulated = alg_done ? manip : noise[0];
   assign alg_net_fail    = alg_done ? net_fail : noise[1];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt      <= 5'h00;
         ctx      <= 5'h00;
         alg_done <= 1'b0;
         noise    <= '0;
      end else begin
         noise    <= ~noise;
         alg_done <= !alg_start && cnt == 5'h01;
         if (alg_start) begin
            cnt <= {1'b0, delay} + 5'h01;
            ctx <= alg_context;
         end else if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
         end
      end
   end
endmodule
`default_nettype wire

// File: bench/test_cacd_decoder.sv
// self-checking bench for the authentication command decoder
`timescale 1ns/10ps
`default_nettype none
module test_cacd_decoder;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, q, st;
   wire  [31:0] prdata;
   wire         pready, pslverr, alg_start, alg_done, alg_manipulated, alg_net_fail;
   wire  [4:0]  alg_context;
   wire  [79:0] alg_result;
   logic        manip = 0, nfail = 0;
   logic [3:0]  dly = 0;
   int          fail_count = 0, samples_checked = 0;
   logic [7:0]  lc_of [1:8] = '{8'h14, 8'h0e, 8'h00, 8'h12, 8'h1b, 8'h1b, 8'h05, 8'h1b};
   initial forever #25 pclk = ~pclk;
   cacd_decoder cacd_decoder_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .alg_start(alg_start), .alg_context(alg_context), .alg_done(alg_done),
      .alg_manipulated(alg_manipulated), .alg_net_fail(alg_net_fail), .alg_result(alg_result));
   cacd_engine cacd_engine_i (.pclk(pclk), .presetn(presetn), .alg_start(alg_start),
      .alg_context(alg_context), .alg_done(alg_done), .alg_manipulated(alg_manipulated),
      .alg_net_fail(alg_net_fail), .alg_result(alg_result), .manip(manip), .net_fail(nfail),
      .delay(dly));
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin fail_count++; end_of_test; end
      q = prdata;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   task run(input logic [7:0] ins, p1, p2, le, lc, rec, input logic [1:0] ok,
      input logic [15:0] sw, input int rlen);
      int n;
      apb(1, 12'h080, {24'h0, rec}); apb(1, 12'h00c, {24'h0, lc});
      apb(1, 12'h008, {le, p2, p1, ins}); apb(1, 12'h000, {29'h0, ok, 1'b1});
      n = 0;
      do begin apb(0, 12'h004, 0); n++; end while (q[1] !== 1'b1 && n < 40);
      if (n >= 40) begin fail_count++; end_of_test; end
      st = q;
      apb(0, 12'h00c, 0); cmp("status word", {16'h0, sw}, {16'h0, q[31:16]});
      if (rlen > 0) cmp("response length", rlen, {24'h0, st[15:8]});
      for (n = 1; n <= 11 && rlen > 0; n++) begin
         apb(0, 12'h020 + 12'(4*(n-1)), 0);
         cmp("response byte", n <= rlen ? {p2[3:0], 4'(n)} : 8'h00, {24'h0, q[7:0]});
      end
      apb(1, 12'h000, 32'h8);
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task t_contexts;
      int r;
      for (int c = 1; c <= 8; c++) begin
         r = c < 3 ? 4 : (c == 3 || c == 7) ? 10 : 0;
         run(8'h88, 8'h00, 8'h80 | 8'(c), 8'h00, lc_of[c], 8'h01, 2'b11,
            r > 0 ? {8'h61, 8'(r)} : 16'h9000, r);
      end
   endtask
   task t_refuse;
      run(8'h89, 8'h00, 8'h81, 8'h00, 8'h14, 8'h01, 2'b11, 16'h6d00, 0);
      run(8'h88, 8'h01, 8'h81, 8'h00, 8'h14, 8'h01, 2'b11, 16'h6a86, 0);
      run(8'h88, 8'h00, 8'h01, 8'h00, 8'h14, 8'h01, 2'b11, 16'h6a86, 0);
      run(8'h88, 8'h00, 8'ha1, 8'h00, 8'h14, 8'h01, 2'b11, 16'h6a86, 0);
      run(8'h88, 8'h00, 8'hc1, 8'h00, 8'h14, 8'h01, 2'b11, 16'h6a86, 0);
      run(8'h88, 8'h00, 8'h80, 8'h00, 8'h14, 8'h01, 2'b11, 16'h6a86, 0);
      run(8'h88, 8'h00, 8'h89, 8'h00, 8'h14, 8'h01, 2'b11, 16'h6a86, 0);
      run(8'h88, 8'h00, 8'h9f, 8'h00, 8'h14, 8'h01, 2'b11, 16'h6a86, 0);
      run(8'h88, 8'h00, 8'h81, 8'h00, 8'h14, 8'h01, 2'b01, 16'h6982, 0);
      run(8'h88, 8'h00, 8'h81, 8'h00, 8'h14, 8'h01, 2'b10, 16'h6982, 0);
   endtask
   task t_lengths;
      run(8'h88, 8'h00, 8'h81, 8'h02, 8'h14, 8'h01, 2'b11, 16'h6102, 2);
      run(8'h88, 8'h00, 8'h83, 8'h0c, 8'h00, 8'h01, 2'b11, 16'h610a, 10);
      run(8'h88, 8'h00, 8'h82, 8'h00, 8'h0d, 8'h01, 2'b11, 16'h6700, 0);
      run(8'h88, 8'h00, 8'h87, 8'h00, 8'h05, 8'h03, 2'b11, 16'h6a80, 0);
      run(8'h88, 8'h00, 8'h87, 8'h00, 8'h05, 8'h02, 2'b11, 16'h610a, 10);
   endtask
   task t_flags;
      manip <= 1; dly <= 4'h9;
      run(8'h88, 8'h00, 8'h84, 8'h00, 8'h12, 8'h01, 2'b11, 16'h9860, 0);
      nfail <= 1;
      run(8'h88, 8'h00, 8'h85, 8'h00, 8'h1b, 8'h01, 2'b11, 16'h9860, 0);
      manip <= 0; dly <= 4'h0;
      run(8'h88, 8'h00, 8'h82, 8'h00, 8'h0e, 8'h01, 2'b11, 16'h9870, 0);
      nfail <= 0;
   endtask
   task t_group;
      apb(0, 12'h010, 0); cmp("group codes at reset", 0, q);
      apb(0, 12'hffc, 0); cmp("unmapped read", 0, q);
      run(8'h88, 8'h00, 8'h89, 8'h00, 8'h12, 8'h01, 2'b11, 16'h6a86, 0);
      apb(1, 12'h010, 32'h8a89);
      run(8'h88, 8'h00, 8'h89, 8'h00, 8'h12, 8'h01, 2'b11, 16'h9000, 0);
      run(8'h88, 8'h00, 8'h8a, 8'h00, 8'h12, 8'h02, 2'b11, 16'h9000, 0);
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_contexts;
      t_refuse;
      t_lengths;
      t_flags;
      t_group;
      end_of_test;
   end
endmodule
`default_nettype wire

// File: hdl/cacd_consts.vh
// constants and bulleted behaviour list for the card authentication command decoder
// What this block does
// - authentication command is instruction 88 with first parameter 00
// - expected length 00 means full response, otherwise caps returned bytes
// - second parameter b8 must be 1, b7 b6 zero, low five bits are context
// - contexts 1 card auth, 2 network auth, 3 key combination, 4 common unseal
// - contexts 5 group unseal, 6 static unseal, 7 modified group, 8 session rekey
// - any other second parameter coding is reserved and never executed unless it is a set group addressed code
// - card auth data: bytes 1-10 challenge, 11-20 random seed
// - network auth data: bytes 1-4 network response, 5-14 random seed
// - common unseal data: 1-15 sealed key, 16-17 identifier, 18 record
// - group unseal data: 1-15 sealed key, 16-17 version, 18-27 rekey seed
// - static unseal data: 1-15 sealed key, 16-17 version, 18-27 rekey seed
// - modified group data: 1 common record, 2-3 key number, 4-5 version
// - modified group common record selector must be 1 or 2
// - session rekey data: 1-15 sealed key, 16-17 version, 18-27 rekey seed
// - group addressed static: 1 session record, 2-16 sealed key, 17-18 version
// - group addressed group: 1 session record, 2-16 sealed key, 17-18 version
// - card auth returns four bytes of card response
// - network auth returns four bytes of expected network response
// - key combination returns ten bytes of derived cipher key
// - modified group derivation returns ten bytes of modified group key
// - refuse unless application directory selected and pin verified
// - status 98 60 on manipulation, 98 70 on network auth failure
`ifndef CACD_CONSTS_VH
`define CACD_CONSTS_VH
`define CACD_INS_AUTH      8'h88
`define CACD_P1_AUTH       8'h00
`define CACD_P2_SPECIFIC   7
`define CACD_CTX_MSB       4
`define CACD_CTX_CARD      5'h01
`define CACD_CTX_NET       5'h02
`define CACD_CTX_DKC       5'h03
`define CACD_CTX_CCK       5'h04
`define CACD_CTX_GCK       5'h05
`define CACD_CTX_SCK       5'h06
`define CACD_CTX_MGK       5'h07
`define CACD_CTX_GSK       5'h08
`define CACD_LEN_CARD      8'h14
`define CACD_LEN_NET       8'h0e
`define CACD_LEN_DKC       8'h00
`define CACD_LEN_CCK       8'h12
`define CACD_LEN_UNSEAL    8'h1b
`define CACD_LEN_MGK       8'h05
`define CACD_LEN_GA        8'h12
`define CACD_RSP_SHORT     8'h04
`define CACD_RSP_LONG      8'h0a
`define CACD_REC_LO        8'h01
`define CACD_REC_HI        8'h02
`define CACD_SW_OK         16'h9000
`define CACD_SW_MANIP      16'h9860
`define CACD_SW_NETFAIL    16'h9870
`define CACD_SW_NOACCESS   16'h6982
`define CACD_SW_WRONGLEN   16'h6700
`define CACD_SW_BADP1P2    16'h6a86
`define CACD_SW_BADINS     16'h6d00
`define CACD_SW_BADDATA    16'h6a80
`define CACD_SW_RSPAVAIL   8'h61
`define CACD_MAX_DATA      27
`define CACD_A_CTRL        12'h000
`define CACD_A_STATUS      12'h004
`define CACD_A_CMD         12'h008
`define CACD_A_SW          12'h00c
`define CACD_A_GA          12'h010
`define CACD_A_RSP0        12'h020
`define CACD_A_DATA0       12'h080
`define CACD_A_RESULT      12'h014
`endif

// File: hdl/cacd_decoder.v
// authentication command decoder with apb register access
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "cacd_consts.vh"
module cacd_decoder #(
   parameter DATA_BYTES = `CACD_MAX_DATA
) (
   // apb
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // algorithm engine
   output reg         alg_start,
   output reg  [4:0]  alg_context,
   input  wire        alg_done,
   input  wire        alg_manipulated,
   input  wire        alg_net_fail,
   input  wire [79:0] alg_result
);

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_RUN  = 2'h1;

   reg [1:0]   state;
   reg         dir_selected;
   reg         pin_verified;
   reg [4:0]   ga_static_code;
   reg [4:0]   ga_group_code;
   reg         ga_static_en;
   reg         ga_group_en;
   reg [7:0]   cmd_ins;
   reg [7:0]   cmd_p1;
   reg [7:0]   cmd_p2;
   reg [7:0]   cmd_lc;
   reg [7:0]   cmd_le;
   reg [7:0]   data_mem [0:DATA_BYTES-1];
   reg [15:0]  status_word;
   reg [7:0]   rsp_len;
   reg [79:0]  rsp_data;
   reg         busy;
   reg         done_flag;
   reg [4:0]   run_ctx;

   wire wr_en = psel & penable & pwrite;
   wire rd_en = psel & penable & ~pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // ----------------------------------------------------------
   // command decode
   // ----------------------------------------------------------
   wire [4:0] ctx = cmd_p2[`CACD_CTX_MSB:0];
   wire p2_form_ok = cmd_p2[`CACD_P2_SPECIFIC] & ~cmd_p2[6] & ~cmd_p2[5];
   wire is_ga_static = ga_static_en & (ctx == ga_static_code);
   wire is_ga_group  = ga_group_en & (ctx == ga_group_code);
   reg        ctx_known;
   reg [7:0]  need_len;
   reg [4:0]  eff_ctx;
   always @* begin
      ctx_known = 1'b1;
      eff_ctx   = ctx;
      need_len  = 8'h00;
      if (is_ga_static | is_ga_group) begin
         need_len = `CACD_LEN_GA;
      end else begin
         case (ctx)
            `CACD_CTX_CARD: need_len = `CACD_LEN_CARD;
            `CACD_CTX_NET:  need_len = `CACD_LEN_NET;
            `CACD_CTX_DKC:  need_len = `CACD_LEN_DKC;
            `CACD_CTX_CCK:  need_len = `CACD_LEN_CCK;
            `CACD_CTX_GCK:  need_len = `CACD_LEN_UNSEAL;
            `CACD_CTX_SCK:  need_len = `CACD_LEN_UNSEAL;
            `CACD_CTX_MGK:  need_len = `CACD_LEN_MGK;
            `CACD_CTX_GSK:  need_len = `CACD_LEN_UNSEAL;
            default:        ctx_known = 1'b0;
         endcase
      end
   end

   // record selector of the modified group context must be 1 or 2
   wire rec_ok = (ctx != `CACD_CTX_MGK) | is_ga_static | is_ga_group |
                 (data_mem[0] == `CACD_REC_LO) | (data_mem[0] == `CACD_REC_HI);

   // response length per context, capped by expected length
   reg [7:0] full_len;
   always @* begin
      case (run_ctx)
         `CACD_CTX_CARD: full_len = `CACD_RSP_SHORT;
         `CACD_CTX_NET:  full_len = `CACD_RSP_SHORT;
         `CACD_CTX_DKC:  full_len = `CACD_RSP_LONG;
         `CACD_CTX_MGK:  full_len = `CACD_RSP_LONG;
         default:        full_len = 8'h00;
      endcase
   end
   wire [7:0] capped_len = ((cmd_le != 8'h00) && (cmd_le < full_len)) ?
                           cmd_le : full_len;

   // ----------------------------------------------------------
   // execute strobe and checks
   // ----------------------------------------------------------
   wire exec_wr = wr_en & (paddr == `CACD_A_CTRL) & pwdata[0] & ~busy;
   // access bits written with the exec strobe count for that same command
   wire ctrl_wr   = wr_en & (paddr == `CACD_A_CTRL);
   wire access_ok = ctrl_wr ? (pwdata[1] & pwdata[2]) : (dir_selected & pin_verified);
   reg  [15:0] check_sw;
   always @* begin
      if (cmd_ins != `CACD_INS_AUTH)
         check_sw = `CACD_SW_BADINS;
      else if (cmd_p1 != `CACD_P1_AUTH)
         check_sw = `CACD_SW_BADP1P2;
      else if (~access_ok)
         check_sw = `CACD_SW_NOACCESS;
      else if (~p2_form_ok | ~ctx_known)
         check_sw = `CACD_SW_BADP1P2;
      else if (cmd_lc != need_len)
         check_sw = `CACD_SW_WRONGLEN;
      else if (~rec_ok)
         check_sw = `CACD_SW_BADDATA;
      else
         check_sw = `CACD_SW_OK;
   end

   // ----------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------
   integer i;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state          <= ST_IDLE;
         busy           <= 1'b0;
         done_flag      <= 1'b0;
         alg_start      <= 1'b0;
         alg_context    <= 5'h00;
         run_ctx        <= 5'h00;
         status_word    <= `CACD_SW_OK;
         rsp_len        <= 8'h00;
         rsp_data       <= 80'h0;
         dir_selected   <= 1'b0;
         pin_verified   <= 1'b0;
         ga_static_en   <= 1'b0;
         ga_group_en    <= 1'b0;
         ga_static_code <= 5'h00;
         ga_group_code  <= 5'h00;
         cmd_ins        <= 8'h00;
         cmd_p1         <= 8'h00;
         cmd_p2         <= 8'h00;
         cmd_lc         <= 8'h00;
         cmd_le         <= 8'h00;
         for (i = 0; i < DATA_BYTES; i = i + 1)
            data_mem[i] <= 8'h00;
      end else begin
         alg_start <= 1'b0;
         if (wr_en && paddr == `CACD_A_CTRL) begin
            dir_selected <= pwdata[1];
            pin_verified <= pwdata[2];
            if (pwdata[3])
               done_flag <= 1'b0;
         end
         if (wr_en && paddr == `CACD_A_GA && ~busy) begin
            ga_static_code <= pwdata[4:0];
            ga_static_en   <= pwdata[7];
            ga_group_code  <= pwdata[12:8];
            ga_group_en    <= pwdata[15];
         end
         if (wr_en && paddr == `CACD_A_CMD && ~busy) begin
            cmd_ins <= pwdata[7:0];
            cmd_p1  <= pwdata[15:8];
            cmd_p2  <= pwdata[23:16];
            cmd_le  <= pwdata[31:24];
         end
         if (wr_en && paddr == `CACD_A_SW && ~busy)
            cmd_lc <= pwdata[7:0];
         for (i = 0; i < DATA_BYTES; i = i + 1)
            if (wr_en && ~busy && paddr == (`CACD_A_DATA0 + 12'h004 * i[11:0]))
               data_mem[i] <= pwdata[7:0];
         case (state)
            ST_IDLE: begin
               if (exec_wr) begin
                  if (check_sw == `CACD_SW_OK) begin
                     state       <= ST_RUN;
                     busy        <= 1'b1;
                     alg_start   <= 1'b1;
                     alg_context <= eff_ctx;
                     run_ctx     <= eff_ctx;
                     rsp_len     <= 8'h00;
                  end else begin
                     status_word <= check_sw;
                     rsp_len     <= 8'h00;
                     done_flag   <= 1'b1;
                  end
               end
            end
            ST_RUN: begin
               if (alg_done) begin
                  state     <= ST_IDLE;
                  busy      <= 1'b0;
                  done_flag <= 1'b1;
                  if (alg_manipulated) begin
                     status_word <= `CACD_SW_MANIP;
                     rsp_len     <= 8'h00;
                  end else if (alg_net_fail) begin
                     status_word <= `CACD_SW_NETFAIL;
                     rsp_len     <= 8'h00;
                  end else if (full_len != 8'h00) begin
                     // data kept in rsp_data, read back through the response window
                     status_word <= {`CACD_SW_RSPAVAIL, capped_len};
                     rsp_len     <= capped_len;
                     rsp_data    <= alg_result;
                  end else begin
                     status_word <= `CACD_SW_OK;
                     rsp_len     <= 8'h00;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------
   // data bytes, byte 1 is data_mem[0]
   // ----------------------------------------------------------

   // ----------------------------------------------------------
   // read mux
   // ----------------------------------------------------------
   integer k;
   always @* begin
      prdata = 32'h0;
      if (rd_en) begin
         if (paddr == `CACD_A_CTRL)
            prdata = {29'h0, pin_verified, dir_selected, 1'b0};
         else if (paddr == `CACD_A_STATUS)
            prdata = {16'h0, rsp_len, 5'h0, ctx_known, done_flag, busy};
         else if (paddr == `CACD_A_CMD)
            prdata = {cmd_le, cmd_p2, cmd_p1, cmd_ins};
         else if (paddr == `CACD_A_SW)
            prdata = {status_word, 8'h00, cmd_lc};
         else if (paddr == `CACD_A_GA)
            prdata = {16'h0, ga_group_en, 2'h0, ga_group_code,
                      ga_static_en, 2'h0, ga_static_code};
         for (k = 0; k < 10; k = k + 1)
            if (paddr == (`CACD_A_RSP0 + 12'h004 * k[11:0]))
               prdata = ({24'h0, rsp_data[79 - 8*k -: 8]}) &
                        {32{(k[7:0] < rsp_len)}};
         for (k = 0; k < DATA_BYTES; k = k + 1)
            if (paddr == (`CACD_A_DATA0 + 12'h004 * k[11:0]))
               prdata = {24'h0, data_mem[k]};
      end
   end

endmodule
`default_nettype wire
